/* File: timer8.sv */
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module timer8 (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [timer8_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o,
	// CPU side
	input wire logic global_irq_en_i,
	input wire logic ack_cmp_a_i,
	input wire logic ack_cmp_b_i,
	input wire logic ack_ovf_i,
	output logic irq_cmp_a_o,
	output logic irq_cmp_b_o,
	output logic irq_ovf_o,
	// Pins
	input wire logic external_count_pin_i,
	output logic wave_output_a_o,
	output logic wave_output_a_oe_o,
	output logic wave_output_b_o,
	output logic wave_output_b_oe_o
);
	import timer8_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers and decode

	logic [7:0] ctrl_a_q;
	logic wave_hi_q;
	logic [2:0] cs_q;
	logic [7:0] cnt_q;
	logic down_q;
	logic blk_q;
	logic [7:0] cmp_buf_q [2];
	logic [7:0] cmp_act_q [2];
	logic [2:0] mask_q;
	logic [2:0] flags_q;
	logic [2:0] irq_q;
	logic [7:0] rdata_q;
	logic [PRESC_W-1:0] presc_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic wr_ctrl_a;
	logic wr_ctrl_b;
	logic wr_count;
	logic wr_cmp_a;
	logic wr_cmp_b;
	logic wr_mask;
	logic wr_flags;
	logic tick;
	logic [2:0] wave_mode;
	logic is_pwm;
	logic is_phase;
	logic is_ctc;
	logic top_is_cmp;
	logic [7:0] top_val;
	logic at_top;
	logic at_bottom;
	logic ovf_ev;
	logic [1:0] match_v;
	logic [1:0] force_v;
	logic [1:0] om [2];
	logic [2:0] set_v;
	logic [2:0] clr_v;

	// Write decode, one target per strobe
	always_comb
	begin
		wr_ctrl_a = 1'b0;
		wr_ctrl_b = 1'b0;
		wr_count = 1'b0;
		wr_cmp_a = 1'b0;
		wr_cmp_b = 1'b0;
		wr_mask = 1'b0;
		wr_flags = 1'b0;
		if (reg_we_i)
		begin
			if (reg_addr_i == OFS_CTRL_A)
				wr_ctrl_a = 1'b1;
			else if (reg_addr_i == OFS_CTRL_B)
				wr_ctrl_b = 1'b1;
			else if (reg_addr_i == OFS_COUNT)
				wr_count = 1'b1;
			else if (reg_addr_i == OFS_CMP_A)
				wr_cmp_a = 1'b1;
			else if (reg_addr_i == OFS_CMP_B)
				wr_cmp_b = 1'b1;
			else if (reg_addr_i == OFS_MASK)
				wr_mask = 1'b1;
			else if (reg_addr_i == OFS_FLAGS)
				wr_flags = 1'b1;
		end
	end

	// Control registers; reserved bits are never stored
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_a_q <= CTRL_A_RST;
			wave_hi_q <= CTRL_B_RST[CB_WAVE_HI];
			cs_q <= CTRL_B_RST[CB_CS_LSB +: 3];
			mask_q <= MASK_RST;
		end
		else
		begin
			if (wr_ctrl_a)
				ctrl_a_q <= {reg_wdata_i[7:4], 2'h0, reg_wdata_i[1:0]};
			if (wr_ctrl_b)
			begin
				wave_hi_q <= reg_wdata_i[CB_WAVE_HI];
				cs_q <= reg_wdata_i[CB_CS_LSB +: 3];
			end
			if (wr_mask)
				mask_q <= reg_wdata_i[2:0];
		end
	end

	// Mode decode; PWM modes are the odd codes
	assign wave_mode = {wave_hi_q, ctrl_a_q[CA_WAVE_LSB +: 2]};
	assign is_pwm = wave_mode[0];
	assign is_phase = (wave_mode[1:0] == 2'h1);
	assign is_ctc = (wave_mode[1:0] == 2'h2);
	assign top_is_cmp = (wave_mode[2] & is_pwm) | is_ctc; // Reserved mode 4 keeps fixed top
	assign top_val = top_is_cmp ? cmp_act_q[0] : COUNT_MAX;
	assign at_top = (cnt_q == top_val);
	assign at_bottom = (cnt_q == COUNT_BOTTOM);
	assign om[0] = ctrl_a_q[CA_MODE_A_LSB +: 2];
	assign om[1] = ctrl_a_q[CA_MODE_B_LSB +: 2];

	////////////////////////////////////////////////////////////////////////////////
	// Clock source

	// Free-running prescaler shared by all divided taps
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			presc_q <= '0;
		else
			presc_q <= presc_q + 1'b1;
	end

	// Pin synchroniser; the second and third stages feed the edge detector
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end
		else
		begin
			ext_s1_q <= external_count_pin_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// Timer tick; pin direction is not looked at, so driven pins still count
	always_comb
	begin
		case (cs_q)
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = &presc_q[2:0];
			CS_DIV64: tick = &presc_q[5:0];
			CS_DIV256: tick = &presc_q[7:0];
			CS_DIV1024: tick = &presc_q;
			CS_EXT_FALL: tick = ext_s3_q & ~ext_s2_q;
			CS_EXT_RISE: tick = ~ext_s3_q & ext_s2_q;
			default: tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter

	// Software write wins over a tick in the same cycle
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= COUNT_RST;
			down_q <= 1'b0;
		end
		else if (wr_count)
			cnt_q <= reg_wdata_i;
		else if (tick)
		begin
			if (!is_phase)
			begin
				down_q <= 1'b0;
				cnt_q <= at_top ? COUNT_BOTTOM : cnt_q + 8'h01;
			end
			else if (down_q)
			begin
				down_q <= !at_bottom;
				cnt_q <= at_bottom ? cnt_q + 8'h01 : cnt_q - 8'h01;
			end
			else
			begin
				down_q <= at_top;
				cnt_q <= at_top ? cnt_q - 8'h01 : cnt_q + 8'h01;
			end
		end
	end

	// Match blocker; held until the next tick after a counter write
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			blk_q <= 1'b0;
		else if (wr_count)
			blk_q <= 1'b1;
		else if (tick)
			blk_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare channels

	// Compare buffers; PWM modes load the live value only at TOP to avoid glitches
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cmp_buf_q[0] <= CMP_RST;
			cmp_buf_q[1] <= CMP_RST;
			cmp_act_q[0] <= CMP_RST;
			cmp_act_q[1] <= CMP_RST;
		end
		else
		begin
			if (wr_cmp_a)
				cmp_buf_q[0] <= reg_wdata_i;
			if (wr_cmp_b)
				cmp_buf_q[1] <= reg_wdata_i;
			if (!is_pwm || (tick && at_top))
			begin
				cmp_act_q[0] <= cmp_buf_q[0];
				cmp_act_q[1] <= cmp_buf_q[1];
			end
		end
	end

	// Per-channel match, force strobe and waveform output
	for (genvar ch = 0; ch < 2; ch++)
	begin : gen_ch
		logic wave_q;
		logic oe_q;
		logic tog_ok;

		assign match_v[ch] = tick && !blk_q && (cnt_q == cmp_act_q[ch]);
		assign force_v[ch] = wr_ctrl_b && reg_wdata_i[CB_FORCE_A - ch] && !is_pwm;
		// Toggle in PWM only for channel A with compare-topped modes
		assign tog_ok = (ch == 0) && wave_hi_q && (om[ch] == OM_TOGGLE);

		// Output level; forced compare touches only this flop
		always_ff @(posedge mclk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				wave_q <= 1'b0;
			else if (!is_pwm)
			begin
				if (match_v[ch] || force_v[ch])
				begin
					case (om[ch])
						OM_TOGGLE: wave_q <= ~wave_q;
						OM_CLEAR: wave_q <= 1'b0;
						OM_SET: wave_q <= 1'b1;
						default: wave_q <= wave_q;
					endcase
				end
			end
			else if (is_phase)
			begin
				if (match_v[ch] && om[ch][1])
					wave_q <= down_q ^ om[ch][0];
				else if (match_v[ch] && tog_ok)
					wave_q <= ~wave_q;
			end
			else if (om[ch][1])
			begin
				// Level at TOP wins when compare equals TOP
				if (tick && at_top)
					wave_q <= ~om[ch][0];
				else if (match_v[ch])
					wave_q <= om[ch][0];
			end
			else if (match_v[ch] && tog_ok)
				wave_q <= ~wave_q;
		end

		// Pin drive enable; PWM code 01 drives the pin only for channel A in compare-topped modes
		always_ff @(posedge mclk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				oe_q <= 1'b0;
			else if (is_pwm && (om[ch] == OM_TOGGLE))
				oe_q <= tog_ok;
			else
				oe_q <= (om[ch] != OM_OFF);
		end
	end

	assign wave_output_a_o = gen_ch[0].wave_q;
	assign wave_output_a_oe_o = gen_ch[0].oe_q;
	assign wave_output_b_o = gen_ch[1].wave_q;
	assign wave_output_b_oe_o = gen_ch[1].oe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Flags and interrupt requests

	// Overflow point follows the waveform mode
	assign ovf_ev = tick && (is_phase ? (down_q && at_bottom) :
		((wave_mode == WAVE_FAST_CMP) ? at_top : (cnt_q == COUNT_MAX)));
	// Forced compares never reach the flags
	assign set_v = {match_v[1], match_v[0], ovf_ev};
	assign clr_v = ({3{wr_flags}} & reg_wdata_i[2:0])
		| {ack_cmp_b_i, ack_cmp_a_i, ack_ovf_i};

	// Set beats clear so no event is lost in the clearing cycle
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			flags_q <= FLAGS_RST;
		else
			flags_q <= set_v | (flags_q & ~clr_v);
	end

	// Requests registered, one cycle behind the flag
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_q <= 3'h0;
		else
			irq_q <= flags_q & mask_q & {3{global_irq_en_i}};
	end

	assign irq_cmp_b_o = irq_q[IRQ_B];
	assign irq_cmp_a_o = irq_q[IRQ_A];
	assign irq_ovf_o = irq_q[IRQ_OVF];

	////////////////////////////////////////////////////////////////////////////////
	// Read port

	// Data valid only in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_q <= 8'h00;
		else if (!reg_re_i)
			rdata_q <= 8'h00;
		else if (reg_addr_i == OFS_CTRL_A)
			rdata_q <= ctrl_a_q;
		else if (reg_addr_i == OFS_CTRL_B)
			rdata_q <= {4'h0, wave_hi_q, cs_q};
		else if (reg_addr_i == OFS_COUNT)
			rdata_q <= cnt_q;
		else if (reg_addr_i == OFS_CMP_A)
			rdata_q <= cmp_buf_q[0];
		else if (reg_addr_i == OFS_CMP_B)
			rdata_q <= cmp_buf_q[1];
		else if (reg_addr_i == OFS_MASK)
			rdata_q <= {5'h00, mask_q};
		else if (reg_addr_i == OFS_FLAGS)
			rdata_q <= {5'h00, flags_q};
		else
			rdata_q <= 8'h00;
	end

	assign reg_rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_force_a_pwm;
		@(posedge mclk_i) disable iff (!rst_n_i)
		is_pwm && wr_ctrl_b && reg_wdata_i[CB_FORCE_A] && !tick |=> $stable(wave_output_a_o);
	endproperty
	a_force_a_pwm: assert property (p_force_a_pwm) else $error("force A acted in PWM");

	property p_force_b_pwm;
		@(posedge mclk_i) disable iff (!rst_n_i)
		is_pwm && wr_ctrl_b && reg_wdata_i[CB_FORCE_B] && !tick |=> $stable(wave_output_b_o);
	endproperty
	a_force_b_pwm: assert property (p_force_b_pwm) else $error("force B acted in PWM");

	property p_force_toggle;
		@(posedge mclk_i) disable iff (!rst_n_i)
		force_v[0] && !match_v[0] && (om[0] == OM_TOGGLE) |=> wave_output_a_o != $past(wave_output_a_o);
	endproperty
	a_force_toggle: assert property (p_force_toggle) else $error("force A did not toggle");

	property p_force_quiet;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wr_ctrl_b && !tick |=> !$rose(flags_q[IRQ_A]) && !$rose(flags_q[IRQ_B]) && $stable(cnt_q);
	endproperty
	a_force_quiet: assert property (p_force_quiet) else $error("force disturbed flags or counter");

	property p_ctrl_b_read;
		@(posedge mclk_i) disable iff (!rst_n_i)
		reg_re_i && (reg_addr_i == OFS_CTRL_B) |=> reg_rdata_o[7:4] == 4'h0;
	endproperty
	a_ctrl_b_read: assert property (p_ctrl_b_read) else $error("control B upper bits not zero");

	property p_stopped;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(cs_q == CS_STOP) && !wr_count |=> $stable(cnt_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

	property p_ext_rise;
		@(posedge mclk_i) disable iff (!rst_n_i)
		($rose(external_count_pin_i) && cs_q == CS_EXT_RISE) ##1 (cs_q == CS_EXT_RISE) [*2] |-> tick;
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("pin rise did not tick");

	property p_block;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wr_count ##1 tick |-> match_v == 2'h0;
	endproperty
	a_block: assert property (p_block) else $error("match after counter write");

	property p_flag_a;
		@(posedge mclk_i) disable iff (!rst_n_i)
		tick && !blk_q && (cnt_q == cmp_act_q[0]) |=> flags_q[IRQ_A];
	endproperty
	a_flag_a: assert property (p_flag_a) else $error("compare A flag not set");

	property p_w1c;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wr_flags && reg_wdata_i[IRQ_OVF] && !ovf_ev |=> !flags_q[IRQ_OVF];
	endproperty
	a_w1c: assert property (p_w1c) else $error("overflow flag not cleared");

	property p_irq;
		@(posedge mclk_i) disable iff (!rst_n_i)
		flags_q[IRQ_A] && mask_q[IRQ_A] && global_irq_en_i |=> irq_cmp_a_o;
	endproperty
	a_irq: assert property (p_irq) else $error("compare A request missing");

	property p_ovf_max;
		@(posedge mclk_i) disable iff (!rst_n_i)
		tick && !wr_count && (wave_mode == 3'h0) && (cnt_q == COUNT_MAX)
			|=> flags_q[IRQ_OVF] ##0 cnt_q == 8'h00;
	endproperty
	a_ovf_max: assert property (p_ovf_max) else $error("normal mode overflow wrong");
endmodule

/* File: timer8_pkg.sv */
package timer8_pkg;
	// Register bus
	localparam int unsigned ADDR_W = 3;
	localparam logic [2:0] OFS_CTRL_A = 3'h0;
	localparam logic [2:0] OFS_CTRL_B = 3'h1;
	localparam logic [2:0] OFS_COUNT = 3'h2;
	localparam logic [2:0] OFS_CMP_A = 3'h3;
	localparam logic [2:0] OFS_CMP_B = 3'h4;
	localparam logic [2:0] OFS_MASK = 3'h5;
	localparam logic [2:0] OFS_FLAGS = 3'h6;

	// Control A fields
	localparam int CA_MODE_A_LSB = 6;
	localparam int CA_MODE_B_LSB = 4;
	localparam int CA_WAVE_LSB = 0;

	// Control B fields
	localparam int CB_FORCE_A = 7;
	localparam int CB_FORCE_B = 6;
	localparam int CB_WAVE_HI = 3;
	localparam int CB_CS_LSB = 0;

	// Mask and flag bit positions
	localparam int IRQ_B = 2;
	localparam int IRQ_A = 1;
	localparam int IRQ_OVF = 0;

	// Reset values
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] CMP_RST = 8'h00;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic [2:0] FLAGS_RST = 3'h0;

	// Clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Prescaler width, 1024 states
	localparam int unsigned PRESC_W = 10;

	// Counter landmarks
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;

	// Waveform mode with compare-topped fast PWM
	localparam logic [2:0] WAVE_FAST_CMP = 3'h7;

	// Output mode codes
	localparam logic [1:0] OM_OFF = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR = 2'h2;
	localparam logic [1:0] OM_SET = 2'h3;
endpackage

/* File: timer8_tb.sv */
`timescale 1ns/100ps
module timer8_tb;
	import timer8_pkg::*;

	logic mclk_i, rst_n_i, reg_we_i, reg_re_i, global_irq_en_i, external_count_pin_i;
	logic ack_cmp_a_i, ack_cmp_b_i, ack_ovf_i;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, rd_q;
	logic irq_cmp_a_o, irq_cmp_b_o, irq_ovf_o;
	logic wave_output_a_o, wave_output_a_oe_o, wave_output_b_o, wave_output_b_oe_o;
	int err_count = 0;
	int tests_run = 0;
	int cycles_q = 0;

	timer8 uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .global_irq_en_i(global_irq_en_i),
		.ack_cmp_a_i(ack_cmp_a_i), .ack_cmp_b_i(ack_cmp_b_i), .ack_ovf_i(ack_ovf_i),
		.irq_cmp_a_o(irq_cmp_a_o), .irq_cmp_b_o(irq_cmp_b_o), .irq_ovf_o(irq_ovf_o),
		.external_count_pin_i(external_count_pin_i), .wave_output_a_o(wave_output_a_o),
		.wave_output_a_oe_o(wave_output_a_oe_o), .wave_output_b_o(wave_output_b_o),
		.wave_output_b_oe_o(wave_output_b_oe_o));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, 10 ns period
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// Hang guard, well above the longest sequence
	always @(posedge mclk_i)
	begin
		cycles_q <= cycles_q + 1;
		if (cycles_q == 20000)
		begin
			err_count = err_count + 1;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Single-cycle write strobe; lands at the second edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_we_i <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge mclk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_re_i <= 1'b0;
		#1;
		rd_q = reg_rdata_o;
	endtask

	// Vector-executed pulse, bits {b, a, ovf}
	task automatic ack(input logic [2:0] v);
		@(posedge mclk_i);
		{ack_cmp_b_i, ack_cmp_a_i, ack_ovf_i} <= v;
		@(posedge mclk_i);
		{ack_cmp_b_i, ack_cmp_a_i, ack_ovf_i} <= 3'h0;
	endtask

	task automatic pin_pulses(input int n);
		repeat (n)
		begin
			external_count_pin_i <= 1'b1;
			repeat (4) @(posedge mclk_i);
			external_count_pin_i <= 1'b0;
			repeat (4) @(posedge mclk_i);
		end
		repeat (4) @(posedge mclk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, reserved bits, unmapped index
	task automatic t_regs();
		rd(OFS_CTRL_B);
		chk(rd_q, 8'h00);
		rd(OFS_MASK);
		chk(rd_q, 8'h00);
		wr(OFS_CTRL_B, 8'h38);
		rd(OFS_CTRL_B);
		chk(rd_q, 8'h08);
		wr(OFS_CTRL_B, 8'h00);
		wr(OFS_MASK, 8'hff);
		rd(OFS_MASK);
		chk(rd_q, 8'h07);
		wr(OFS_MASK, 8'h00);
		wr(3'h7, 8'h5a);
		rd(3'h7);
		chk(rd_q, 8'h00);
		wr(OFS_COUNT, 8'ha5);
		rd(OFS_COUNT);
		chk(rd_q, 8'ha5);
		wr(OFS_CMP_A, 8'h40);
		wr(OFS_CMP_B, 8'h80);
		rd(OFS_CMP_B);
		chk(rd_q, 8'h80);
	endtask

	// Every prescaler code over a 1024-cycle window; window = N + 2 edges
	task automatic t_prescale();
		int divs[6] = '{0, 1, 8, 64, 256, 1024};
		for (int c = 0; c < 6; c++)
		begin
			wr(OFS_COUNT, 8'h05);
			wr(OFS_CTRL_B, 8'(c));
			repeat (1022) @(posedge mclk_i);
			wr(OFS_CTRL_B, CS_STOP);
			rd(OFS_COUNT);
			chk(rd_q, 8'(5 + (divs[c] == 0 ? 0 : 1024 / divs[c])));
		end
	endtask

	// Overflow at MAX, mask, global bit, write-one clear and vector clear
	task automatic t_overflow();
		wr(OFS_FLAGS, 8'h07);
		wr(OFS_MASK, 8'h01);
		global_irq_en_i <= 1'b0;
		// Two ticks between the strobes: 0xfe, then 0xff wraps
		wr(OFS_COUNT, 8'hfe);
		wr(OFS_CTRL_B, CS_DIV1);
		wr(OFS_CTRL_B, CS_STOP);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h01);
		chk({7'h0, irq_ovf_o}, 8'h00);
		@(posedge mclk_i);
		global_irq_en_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		chk({7'h0, irq_ovf_o}, 8'h01);
		wr(OFS_FLAGS, 8'h00);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h01);
		wr(OFS_FLAGS, 8'h01);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h00);
		chk({7'h0, irq_ovf_o}, 8'h00);
		wr(OFS_COUNT, 8'hfe);
		wr(OFS_CTRL_B, CS_DIV1);
		wr(OFS_CTRL_B, CS_STOP);
		ack(3'h1);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h00);
	endtask

	// Compare matches, output modes, forced compares in both mode kinds
	task automatic t_compare();
		wr(OFS_CTRL_A, 8'ha0);
		wr(OFS_CTRL_B, 8'hc0);
		#1;
		chk({6'h0, wave_output_b_o, wave_output_a_o}, 8'h00);
		wr(OFS_MASK, 8'h06);
		wr(OFS_CTRL_A, 8'h70);
		wr(OFS_CMP_A, 8'h20);
		wr(OFS_CMP_B, 8'h21);
		wr(OFS_COUNT, 8'h10);
		wr(OFS_FLAGS, 8'h07);
		wr(OFS_CTRL_B, CS_DIV1);
		repeat (30) @(posedge mclk_i);
		wr(OFS_CTRL_B, CS_STOP);
		chk({4'h0, wave_output_b_oe_o, wave_output_b_o, wave_output_a_oe_o, wave_output_a_o},
			8'h0f);
		chk({6'h0, irq_cmp_b_o, irq_cmp_a_o}, 8'h03);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h06);
		ack(3'h6);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h00);
		// Force: A toggles, B clears, then A clears, B sets; no flag, counter kept
		rd(OFS_COUNT);
		wr(OFS_CTRL_A, 8'h60);
		wr(OFS_CTRL_B, 8'hc0);
		#1;
		chk({6'h0, wave_output_b_o, wave_output_a_o}, 8'h00);
		// Clear-on-match mode with the counter sitting on its top value
		wr(OFS_CTRL_A, 8'hb2);
		wr(OFS_COUNT, 8'h20);
		wr(OFS_CTRL_B, 8'hc0);
		#1;
		chk({6'h0, wave_output_b_o, wave_output_a_o}, 8'h02);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h00);
		rd(OFS_COUNT);
		chk(rd_q, 8'h20);
		rd(OFS_CTRL_B);
		chk(rd_q, 8'h00);
		// Phase-correct PWM: strobes leave both outputs as they were
		wr(OFS_CTRL_A, 8'hf1);
		wr(OFS_CTRL_B, 8'hc0);
		#1;
		chk({6'h0, wave_output_b_o, wave_output_a_o}, 8'h02);
		wr(OFS_CTRL_B, 8'h00);
		wr(OFS_CTRL_A, 8'h00);
	endtask

	// Counter write removes the match on the next tick only
	task automatic t_block();
		wr(OFS_COUNT, 8'h20);
		wr(OFS_FLAGS, 8'h07);
		wr(OFS_CTRL_B, CS_DIV1);
		repeat (4) @(posedge mclk_i);
		wr(OFS_CTRL_B, CS_STOP);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h04);
		// Same again with the counter running through the write
		wr(OFS_FLAGS, 8'h07);
		wr(OFS_CTRL_B, CS_DIV1);
		wr(OFS_COUNT, 8'h20);
		repeat (4) @(posedge mclk_i);
		wr(OFS_CTRL_B, CS_STOP);
		rd(OFS_FLAGS);
		chk(rd_q, 8'h04);
	endtask

	// External pin, both edges, synchronised
	task automatic t_extern();
		wr(OFS_COUNT, 8'h00);
		wr(OFS_CTRL_B, CS_EXT_RISE);
		pin_pulses(5);
		wr(OFS_CTRL_B, CS_STOP);
		rd(OFS_COUNT);
		chk(rd_q, 8'h05);
		wr(OFS_COUNT, 8'h00);
		wr(OFS_CTRL_B, CS_EXT_FALL);
		pin_pulses(3);
		wr(OFS_CTRL_B, CS_STOP);
		rd(OFS_COUNT);
		chk(rd_q, 8'h03);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_n_i = 1'b0;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		reg_addr_i = 3'h0;
		reg_wdata_i = 8'h00;
		global_irq_en_i = 1'b0;
		external_count_pin_i = 1'b0;
		{ack_cmp_b_i, ack_cmp_a_i, ack_ovf_i} = 3'h0;
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_prescale();
		t_overflow();
		t_compare();
		t_block();
		t_extern();
		end_sim();
	end
endmodule
